// ==== upsc_defs.svh ====
`ifndef UPSC_DEFS_SVH
`define UPSC_DEFS_SVH
// Settle count after reset release, in clock cycles; straps latch two cycles after it is reached.
`define UPSC_STRAP_SETTLE   4'h8
// Strap vector bit positions.
`define UPSC_S_TXD   0
`define UPSC_S_TXC   1
`define UPSC_S_DTRB  2
`define UPSC_S_TXB   3
`define UPSC_S_CHAN_A_TERMINAL_READY_N  4
`define UPSC_S_TXA   5
`define UPSC_S_DTRC  6
`define UPSC_S_CHAN_A_REQUEST_TO_SEND_N  7
// Positions in the synchronised pin vector.
`define UPSC_P_STRAP_HI 13
`define UPSC_P_STRAP_LO 6
`define UPSC_P_SER      5
`define UPSC_P_IR       4
`define UPSC_P_MDM_HI   3
// Idle pad levels loaded into the synchronisers in reset: straps on
// their pull-ups, serial in high, infrared in low, modem inputs high.
`define UPSC_SYNC_IDLE  14'h3fef
// Configuration port pairs.
`define UPSC_IDX_HI  16'h002e
`define UPSC_DAT_HI  16'h002f
`define UPSC_IDX_LO  16'h004e
`define UPSC_DAT_LO  16'h004f
// Channel A default register values.
`define UPSC_EN_ON   8'h01
`define UPSC_BASE_A1 16'h03f8
`define UPSC_BASE_A2 16'h03e0
`define UPSC_IRQ_A   8'h03
`define UPSC_ZERO8   8'h00
`define UPSC_ZERO16  16'h0000
`endif

// ==== upsc_pkg.sv ====
`default_nettype none
package upsc_pkg;
  // Strap sampling sequence.
  typedef enum logic [1:0] {UPSC_WAIT, UPSC_LATCH, UPSC_RUN} upsc_state_t;
endpackage : upsc_pkg
`default_nettype wire

// ==== upsc_sync.sv ====
`default_nettype none
`include "upsc_defs.svh"
// ------------------------------------------------------------
// Two-stage synchroniser for a vector of pin inputs.
// ------------------------------------------------------------
module upsc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] reset_val,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;  // First stage, read only by the second.

  // Each bit passes through two flip-flops; reset loads the idle level
  // so that no false pin activity shows right after reset.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          meta_r[i]   <= reset_val[i];
          sync_out[i] <= reset_val[i];
        end else begin
          meta_r[i]   <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule : upsc_sync
`default_nettype wire

// ==== upsc_top.sv ====
// Notes on behaviour
// - Serial out idles high, also in reset.
// - Infrared receive low means idle.
// - Infrared transmit low in reset, idle.
// - Sample transmit and ready straps at reset.
// - Software may overwrite strap defaults.
// - Modem inputs active low or general.
// - Modem outputs active low or general.
// - Watchdog output open drain, low only.
// - Request-to-send strap floats high.
// - Request strap picks configuration port pair.
// - Eight straps captured; two select channel A defaults.
`default_nettype none
`include "upsc_defs.svh"
module upsc_top
  import upsc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Strap-shared pins: level seen on the pad.
  input  wire logic [7:0]  strap_pins_in,
  // Serial engine side.
  input  wire logic        tx_bit,
  input  wire logic        tx_busy,
  input  wire logic        ir_bit,
  input  wire logic        ir_busy,
  input  wire logic        rts_val,
  input  wire logic        dtr_val,
  input  wire logic        wdt_fire,
  // Software writes to channel A defaults.
  input  wire logic        sw_wr_en,
  input  wire logic        sw_wr_base,
  input  wire logic        sw_wr_irq,
  input  wire logic [15:0] sw_wdata,
  // Pins.
  input  wire logic        chan_a_serial_in,
  input  wire logic        infrared_receive_in,
  input  wire logic        chan_a_clear_to_send_n,
  input  wire logic        chan_a_set_ready_n,
  input  wire logic        chan_a_carrier_detect_n,
  input  wire logic        chan_a_ring_indicator_n,
  output var  logic        chan_a_serial_out,
  output var  logic        chan_a_serial_out_oe,
  output var  logic        chan_a_request_to_send_n,
  output var  logic        chan_a_request_to_send_oe,
  output var  logic        chan_a_terminal_ready_n,
  output var  logic        chan_a_terminal_ready_oe,
  output var  logic        infrared_transmit_out,
  output var  logic        watchdog_timeout_out,
  output var  logic        watchdog_timeout_oe,
  // Results for the rest of the device.
  output var  logic [7:0]  strap_r,
  output var  logic        straps_done,
  output var  logic [15:0] cfg_index_port,
  output var  logic [15:0] cfg_data_port,
  output var  logic [7:0]  chan_a_enable_r,
  output var  logic [15:0] chan_a_base_r,
  output var  logic [7:0]  chan_a_irq_r,
  output var  logic [3:0]  modem_status,
  output var  logic        rx_line,
  output var  logic        ir_rx_line
);
  // ----------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------
  logic [13:0] pins_async;  // Raw pad levels.
  logic [13:0] pins_sync;   // Levels after two flip-flops.
  assign pins_async = {strap_pins_in, chan_a_serial_in,
                       infrared_receive_in, chan_a_clear_to_send_n,
                       chan_a_set_ready_n, chan_a_carrier_detect_n,
                       chan_a_ring_indicator_n};

  upsc_sync #(.W(14)) u_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .async_in  (pins_async),
    .reset_val (`UPSC_SYNC_IDLE),
    .sync_out  (pins_sync)
  );

  // Modem status is passed active low, usable as general inputs.
  assign modem_status = pins_sync[`UPSC_P_MDM_HI:0];
  assign rx_line      = pins_sync[`UPSC_P_SER];  // High is idle
  assign ir_rx_line   = pins_sync[`UPSC_P_IR];   // Low is idle

  // Strap pad levels as they stand now, after the synchroniser.
  logic [7:0] strap_now;
  assign strap_now = pins_sync[`UPSC_P_STRAP_HI:`UPSC_P_STRAP_LO];

  // ----------------------------------------------------------
  // Strap sampling sequence.
  // ----------------------------------------------------------
  upsc_state_t state_r;       // Current phase.
  upsc_state_t state_nxt;     // Next phase.
  logic [3:0]  settle_r;      // Settle counter after reset.
  logic        settle_done;   // Settle time reached.

  assign settle_done = (settle_r == `UPSC_STRAP_SETTLE);

  // Phase selection.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      UPSC_WAIT: begin
        if (settle_done) begin
          state_nxt = UPSC_LATCH;
        end
      end
      UPSC_LATCH: begin
        state_nxt = UPSC_RUN;
      end
      UPSC_RUN: begin
        state_nxt = UPSC_RUN;  // Held until reset
      end
      default: begin
        state_nxt = UPSC_WAIT;
      end
    endcase
  end

  // Phase register and settle counter.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r  <= UPSC_WAIT;
      settle_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (!settle_done) begin
        settle_r <= settle_r + 4'h1;
      end
    end
  end

  assign straps_done = (state_r == UPSC_RUN);

  // Strap capture once after reset release; pad pull-ups make
  // floating pins read high.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strap_r <= 8'h00;
    end else if (state_r == UPSC_LATCH) begin
      strap_r <= strap_now;
    end
  end

  // ----------------------------------------------------------
  // Strap-derived results.
  // ----------------------------------------------------------
  // The defaults load in the same edge that captures strap_r, so they
  // read the live strap levels; strap_r would still hold reset zeros.
  logic a_tx_s;   // Primary base strap.
  logic a_dtr_s;  // Alternate base strap.
  assign a_tx_s  = strap_now[`UPSC_S_TXA];
  assign a_dtr_s = strap_now[`UPSC_S_CHAN_A_TERMINAL_READY_N];

  // Port pair from request strap
  assign cfg_index_port = strap_r[`UPSC_S_CHAN_A_REQUEST_TO_SEND_N] ? `UPSC_IDX_HI
                                                : `UPSC_IDX_LO;
  assign cfg_data_port  = strap_r[`UPSC_S_CHAN_A_REQUEST_TO_SEND_N] ? `UPSC_DAT_HI
                                                : `UPSC_DAT_LO;

  logic        a_any;      // Either channel A strap high.
  logic [15:0] a_base_d;   // Default base address.
  assign a_any    = a_tx_s | a_dtr_s;
  assign a_base_d = a_tx_s ? `UPSC_BASE_A1 :
                    a_dtr_s ? `UPSC_BASE_A2 : `UPSC_ZERO16;

  // Defaults load at capture, then software writes win.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chan_a_enable_r <= `UPSC_ZERO8;
      chan_a_base_r   <= `UPSC_ZERO16;
      chan_a_irq_r    <= `UPSC_ZERO8;
    end else if (state_r == UPSC_LATCH) begin
      chan_a_enable_r <= a_any ? `UPSC_EN_ON : `UPSC_ZERO8;
      chan_a_base_r   <= a_base_d;
      chan_a_irq_r    <= a_any ? `UPSC_IRQ_A : `UPSC_ZERO8;
    end else if (straps_done) begin
      if (sw_wr_en) begin
        chan_a_enable_r <= sw_wdata[7:0];
      end
      if (sw_wr_base) begin
        chan_a_base_r <= sw_wdata;
      end
      if (sw_wr_irq) begin
        chan_a_irq_r <= sw_wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------
  // Output pins.
  // ----------------------------------------------------------
  // Serial and modem outputs released only after sampling.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chan_a_serial_out        <= 1'b1;
      chan_a_request_to_send_n <= 1'b1;
      chan_a_terminal_ready_n  <= 1'b1;
      infrared_transmit_out    <= 1'b0;
      watchdog_timeout_oe      <= 1'b0;
    end else begin
      chan_a_serial_out <= (straps_done & tx_busy) ? tx_bit
                                                   : 1'b1;
      chan_a_request_to_send_n <= straps_done ? rts_val : 1'b1;
      chan_a_terminal_ready_n  <= straps_done ? dtr_val : 1'b1;
      infrared_transmit_out    <= ir_busy ? ir_bit : 1'b0;
      watchdog_timeout_oe      <= wdt_fire;
    end
  end

  // Strap pins float during sampling
  assign chan_a_serial_out_oe      = straps_done;
  assign chan_a_request_to_send_oe = straps_done;
  assign chan_a_terminal_ready_oe  = straps_done;
  assign watchdog_timeout_out      = 1'b0;

  // ----------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------
  // Serial out returns high one cycle after the engine goes idle.
  AST_TX_IDLE: assert property (
    @(posedge clk_sys) disable iff (reset)
    !tx_busy |=> chan_a_serial_out)
    else $error("serial out not idle high");
  // Infrared out returns low one cycle after the engine goes idle.
  AST_IR_IDLE: assert property (
    @(posedge clk_sys) disable iff (reset)
    !ir_busy |=> !infrared_transmit_out)
    else $error("infrared out not idle low");
  // The open-drain pin only ever pulls low.
  AST_WDT_LOW: assert property (
    @(posedge clk_sys)
    watchdog_timeout_out == 1'b0)
    else $error("watchdog pin driven high");
  // A watchdog request turns the pull-down on in the next cycle.
  AST_WDT_DRIVE: assert property (
    @(posedge clk_sys) disable iff (reset)
    wdt_fire |=> watchdog_timeout_oe)
    else $error("watchdog pin not pulled low");
  // Captured straps never move until the next reset.
  AST_HOLD: assert property (
    @(posedge clk_sys) disable iff (reset)
    straps_done |=> $stable(strap_r))
    else $error("strap value changed");
  // No strap-shared pin is driven before sampling ends.
  AST_NO_DRIVE: assert property (
    @(posedge clk_sys) disable iff (reset)
    !straps_done |-> !chan_a_serial_out_oe && !chan_a_terminal_ready_oe &&
                     !chan_a_request_to_send_oe)
    else $error("strap pin driven early");
  // A high request strap selects the upper port pair.
  AST_PORT: assert property (
    @(posedge clk_sys) disable iff (reset)
    straps_done && strap_r[`UPSC_S_CHAN_A_REQUEST_TO_SEND_N] |->
      cfg_index_port == `UPSC_IDX_HI && cfg_data_port == `UPSC_DAT_HI)
    else $error("wrong index port");
  // A software base write lands in the next cycle.
  AST_SW_WR: assert property (
    @(posedge clk_sys) disable iff (reset)
    straps_done && sw_wr_base |=> chan_a_base_r == $past(sw_wdata))
    else $error("software write lost");
  // Sampling ends a fixed ten cycles after reset release.
  AST_DONE: assert property (
    @(posedge clk_sys)
    $fell(reset) |-> ##10 straps_done)
    else $error("strap sampling late");
  // The request pin follows the engine value one cycle later.
  AST_RTS: assert property (
    @(posedge clk_sys) disable iff (reset)
    straps_done |=> chan_a_request_to_send_n == $past(rts_val))
    else $error("request output wrong");
  COV_DONE: cover property (@(posedge clk_sys) $rose(straps_done));
  COV_LOWPORT: cover property (@(posedge clk_sys)
    straps_done && !strap_r[`UPSC_S_CHAN_A_REQUEST_TO_SEND_N]);
  COV_TX: cover property (@(posedge clk_sys) straps_done && tx_busy);
endmodule : upsc_top
`default_nettype wire

// ==== upsc_strap_model.sv ====
`default_nettype none
// ----------------------------------------------------------
// Board side: strap resistors, pull-ups and the pad levels.
// ----------------------------------------------------------
module upsc_strap_model (
  input  wire logic [7:0] pull_down,
  input  wire logic       tx_out,
  input  wire logic       tx_oe,
  input  wire logic       rts_out,
  input  wire logic       rts_oe,
  input  wire logic       dtr_out,
  input  wire logic       dtr_oe,
  input  wire logic       wdt_out,
  input  wire logic       wdt_oe,
  output logic      [7:0] strap_pad,
  output logic            wdt_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rest_lvl;  // Level set by resistors alone.
  // A pin with no pull-down floats high on its pull-up.
  assign rest_lvl = ~pull_down;
  // A driven strap pin shows the driver, else the resistor level.
  always_comb begin
    strap_pad    = rest_lvl;
    strap_pad[5] = tx_oe  ? tx_out  : rest_lvl[5];
    strap_pad[4] = dtr_oe ? dtr_out : rest_lvl[4];
    strap_pad[7] = rts_oe ? rts_out : rest_lvl[7];
  end
  // The open-drain line rests high on the board pull-up.
  assign wdt_wire = (wdt_oe && !wdt_out) ? 1'b0 : 1'b1;
endmodule : upsc_strap_model
`default_nettype wire

// ==== test_uart_pin_levels_and_strap_capture.sv ====
`default_nettype none
`include "upsc_defs.svh"
module test_uart_pin_levels_and_strap_capture;
  import upsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, reset = 1'b1;
  logic tx_bit = 1'b0, tx_busy = 1'b0, ir_bit = 1'b1, ir_busy = 1'b0;
  logic rts_val = 1'b1, dtr_val = 1'b1, wdt_fire = 1'b0;
  logic sw_wr_en = 1'b0, sw_wr_base = 1'b0, sw_wr_irq = 1'b0;
  // The far side holds the serial line high while idle
  logic ser_in = 1'b1, ir_in = 1'b0;
  logic [15:0] sw_wdata = 16'h0000;
  logic [3:0] mdm_in = 4'hf;
  logic [7:0] pd = 8'h00, pads, strap_r, en_r, irq_r;
  logic [15:0] idx_p, dat_p, base_r;
  logic so, so_oe, rts_n, rts_oe, dtr_n, dtr_oe, ir_out, wd_o, wd_oe;
  logic done, rx_l, irx_l, wd_wire;
  logic [3:0] mstat;
  int miscompares = 0, checked = 0;
  // One system clock stands in for the device clock input
  always #4 clk_sys = ~clk_sys;
  upsc_top i_dut (.clk_sys(clk_sys), .reset(reset),
    .strap_pins_in(pads), .tx_bit(tx_bit), .tx_busy(tx_busy),
    .ir_bit(ir_bit), .ir_busy(ir_busy), .rts_val(rts_val),
    .dtr_val(dtr_val), .wdt_fire(wdt_fire), .sw_wr_en(sw_wr_en),
    .sw_wr_base(sw_wr_base), .sw_wr_irq(sw_wr_irq),
    .sw_wdata(sw_wdata), .chan_a_serial_in(ser_in),
    .infrared_receive_in(ir_in), .chan_a_clear_to_send_n(mdm_in[3]),
    .chan_a_set_ready_n(mdm_in[2]),
    .chan_a_carrier_detect_n(mdm_in[1]),
    .chan_a_ring_indicator_n(mdm_in[0]), .chan_a_serial_out(so),
    .chan_a_serial_out_oe(so_oe), .chan_a_request_to_send_n(rts_n),
    .chan_a_request_to_send_oe(rts_oe),
    .chan_a_terminal_ready_n(dtr_n), .chan_a_terminal_ready_oe(dtr_oe),
    .infrared_transmit_out(ir_out), .watchdog_timeout_out(wd_o),
    .watchdog_timeout_oe(wd_oe), .strap_r(strap_r), .straps_done(done),
    .cfg_index_port(idx_p), .cfg_data_port(dat_p),
    .chan_a_enable_r(en_r), .chan_a_base_r(base_r),
    .chan_a_irq_r(irq_r), .modem_status(mstat), .rx_line(rx_l),
    .ir_rx_line(irx_l));
  upsc_strap_model i_board (.pull_down(pd), .tx_out(so),
    .tx_oe(so_oe), .rts_out(rts_n), .rts_oe(rts_oe), .dtr_out(dtr_n),
    .dtr_oe(dtr_oe), .wdt_out(wd_o), .wdt_oe(wd_oe),
    .strap_pad(pads), .wdt_wire(wd_wire));
  // Inputs move 1 ns after the rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Reset with a strap pattern, then check the captured defaults.
  task automatic strap_case(input logic [7:0] p);
    int n;
    logic a;
    logic [7:0] lvl;
    n = 0;
    a = !p[5] || !p[4];
    lvl = ~p;
    pd = p;
    reset = 1'b1;
    step(3);
    chk(so, 1'b1);
    chk(ir_out, 1'b0);
    chk({so_oe, rts_oe, dtr_oe}, 3'h0);
    reset = 1'b0;
    while (done !== 1'b1 && n < 30) begin
      step(1);
      n++;
    end
    chk(16'(n), 16'(`UPSC_STRAP_SETTLE) + 16'h0002);
    chk({so_oe, rts_oe, dtr_oe}, 3'h7);
    chk(strap_r, lvl);
    chk(idx_p, p[7] ? 16'h004e : 16'h002e);
    chk(dat_p, p[7] ? 16'h004f : 16'h002f);
    chk(base_r, !p[5] ? 16'h03f8 : (!p[4] ? 16'h03e0 : 16'h0000));
    chk({en_r, irq_r}, a ? 16'h0103 : 16'h0000);
  endtask : strap_case
  // Pins change after capture; the straps must not follow.
  task automatic hold_case;
    pd = 8'hff;
    rts_val = 1'b0;
    step(6);
    chk(strap_r, 8'hff);
    chk(rts_n, 1'b0);
    rts_val = 1'b1;
    pd = 8'h00;
  endtask : hold_case
  // Software overwrites the defaults, back to back.
  task automatic sw_case;
    sw_wdata = 16'h02e8;
    sw_wr_base = 1'b1;
    step(1);
    sw_wr_base = 1'b0;
    sw_wr_irq = 1'b1;
    sw_wr_en = 1'b1;
    sw_wdata = 16'h0009;
    step(1);
    sw_wr_irq = 1'b0;
    sw_wr_en = 1'b0;
    step(1);
    chk(base_r, 16'h02e8);
    chk({en_r, irq_r}, 16'h0909);
  endtask : sw_case
  // Line, modem and watchdog pins.
  task automatic pin_case;
    mdm_in = 4'ha;
    dtr_val = 1'b0;
    tx_busy = 1'b1;
    wdt_fire = 1'b1;
    ir_busy = 1'b1;
    step(5);
    chk(ir_out, 1'b1);
    chk(mstat, 4'ha);
    chk({dtr_n, so}, 2'h0);
    chk(wd_wire, 1'b0);
    chk({rx_l, irx_l}, 2'h2);
    tx_busy = 1'b0;
    wdt_fire = 1'b0;
    dtr_val = 1'b1;
    ir_busy = 1'b0;
    ser_in = 1'b0;
    ir_in = 1'b1;
    step(3);
    chk({so, wd_wire, wd_o}, 3'h6);
    chk(ir_out, 1'b0);
    chk({rx_l, irx_l}, 2'h1);
    ser_in = 1'b1;
    ir_in = 1'b0;
  endtask : pin_case
  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    step(12);
    strap_case(8'h00);
    hold_case();
    sw_case();
    strap_case(8'h20);
    strap_case(8'hb0);
    strap_case(8'h4f);
    pin_case();
    report_and_stop();
  end
endmodule : test_uart_pin_levels_and_strap_capture
`default_nettype wire
